// ==== rtl/eqsc_regs.sv ====
// equalizer control, strap decode status and audio clock divider register bank
// ----------------------------------------------------------------------------
// Summary of operation
// - with secondary select set, 0x35 writes go to secondary link controls
// - bit 6 of 0x35 restarts adaptation; software writes one then zero
// - a restart acts on both links whatever port is selected
// - floor start select acts only while floor override enable is one
// - effective floor select starts adaptation from preset floor, not zero
// - 0x37 bit 7 reads one once link strap decode is latched
// - 0x37 bits 6-4 hold link strap decode, bit 6 the msb
// - 0x37 bit 3 reads one once output strap decode is latched
// - 0x37 bits 2-0 hold output strap decode, bit 2 the msb
// - 0x3A bit 7 makes register oscillator output divide selection take effect
// - bits 6-4 choose oscillator output divide 32,16,8,4,2,2,1,1
// - bit 2 makes register input divide override the pll state machine
// - bits 1-0 choose reference divide 1,2,4,8
// - 0x3B bits 5-0 show manual values when bypassed, else adaptive result
// - with secondary select set, 0x3B reads return the secondary link
// - secondary select writes both secondary and shared; reads secondary
// - primary select resets to one
// - 0x44 holds stage-one 7-5, stage-two 3-1 and bypass bit 0
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "eqsc_defs.svh"
module eqsc_regs
   import eqsc_pkg::*;
(
   input  wire logic       CORE_CLK_IN,
   input  wire logic       RESET_IN,
   input  wire logic       REG_WR_IN,
   input  wire logic       REG_RD_IN,
   input  wire logic [7:0] REG_ADDR_IN,
   input  wire logic [7:0] REG_WDATA_IN,
   input  wire logic       LINK_STRAP_VALID_IN,
   input  wire logic [2:0] LINK_STRAP_CODE_IN,
   input  wire logic       OUT_STRAP_VALID_IN,
   input  wire logic [2:0] OUT_STRAP_CODE_IN,
   input  wire logic [5:0] PRI_AEQ_RESULT_IN,
   input  wire logic [5:0] SEC_AEQ_RESULT_IN,
   input  wire logic [2:0] PLL_MDIV_LOG2_IN,
   input  wire logic [1:0] PLL_MSEL_LOG2_IN,
   output logic      [7:0] REG_RDATA_OUT,
   output logic      [5:0] PRI_EQ_SETTING_OUT,
   output logic      [5:0] SEC_EQ_SETTING_OUT,
   output logic            PRI_EQUALIZER_ADAPT_RESTART_OUT,
   output logic            SEC_EQUALIZER_ADAPT_RESTART_OUT,
   output logic            PRI_AEQ_FLOOR_START_OUT,
   output logic            SEC_AEQ_FLOOR_START_OUT,
   output logic      [2:0] MCLK_MDIV_LOG2_OUT,
   output logic      [1:0] MCLK_MSEL_LOG2_OUT
);
   // ------------------------------------------------------------------------
   // strap pin synchronisers
   // ------------------------------------------------------------------------
   logic [1:0] strap_meta_r;
   logic [1:0] strap_sync_r;
   logic [2:0] lcode_meta_r;
   logic [2:0] lcode_sync_r;
   logic [2:0] ocode_meta_r;
   logic [2:0] ocode_sync_r;

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RESET_IN)
      begin
         strap_meta_r <= 2'h0;
         strap_sync_r <= 2'h0;
         lcode_meta_r <= 3'h0;
         lcode_sync_r <= 3'h0;
         ocode_meta_r <= 3'h0;
         ocode_sync_r <= 3'h0;
      end
      else
      begin
         strap_meta_r <= {LINK_STRAP_VALID_IN, OUT_STRAP_VALID_IN};
         strap_sync_r <= strap_meta_r;
         lcode_meta_r <= LINK_STRAP_CODE_IN;
         lcode_sync_r <= lcode_meta_r;
         ocode_meta_r <= OUT_STRAP_CODE_IN;
         ocode_sync_r <= ocode_meta_r;
      end
   end

   // ------------------------------------------------------------------------
   // shared registers: port select, divider select, latched straps
   // ------------------------------------------------------------------------
   logic [7:0]       port_r;
   logic [7:0]       port_nxt;
   logic [7:0]       div_r;
   logic [7:0]       div_nxt;
   eqsc_strap_type   lstrap_r;
   eqsc_strap_type   lstrap_nxt;
   eqsc_strap_type   ostrap_r;
   eqsc_strap_type   ostrap_nxt;
   logic             wr_port;
   logic             wr_div;
   logic             sec_sel;

   assign wr_port = REG_WR_IN && (REG_ADDR_IN == `EQSC_ADDR_PORT_CTL);
   assign wr_div  = REG_WR_IN && (REG_ADDR_IN == `EQSC_ADDR_MCLK_DIV);
   assign sec_sel = port_r[`EQSC_BIT_SEC_SEL];

   always_comb
   begin
      port_nxt   = port_r;
      div_nxt    = div_r;
      lstrap_nxt = lstrap_r;
      ostrap_nxt = ostrap_r;
      if (wr_port)
      begin
         port_nxt = REG_WDATA_IN & 8'h03;
      end
      if (wr_div)
      begin
         div_nxt = REG_WDATA_IN & 8'hF7;
      end
      // first valid decode latched once, then frozen until reset
      if (!lstrap_r.valid && strap_sync_r[1])
      begin
         lstrap_nxt = '{valid: 1'b1, code: lcode_sync_r};
      end
      if (!ostrap_r.valid && strap_sync_r[0])
      begin
         ostrap_nxt = '{valid: 1'b1, code: ocode_sync_r};
      end
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RESET_IN)
      begin
         port_r   <= `EQSC_RST_PORT_CTL;
         div_r    <= `EQSC_RST_MCLK_DIV;
         lstrap_r <= '0;
         ostrap_r <= '0;
      end
      else
      begin
         port_r   <= port_nxt;
         div_r    <= div_nxt;
         lstrap_r <= lstrap_nxt;
         ostrap_r <= ostrap_nxt;
      end
   end

   // ------------------------------------------------------------------------
   // per-link banks
   // ------------------------------------------------------------------------
   logic [7:0] pri_aeq;
   logic [7:0] pri_byp;
   logic [7:0] sec_aeq;
   logic [7:0] sec_byp;
   logic       wr_aeq;
   logic       wr_byp;

   assign wr_aeq = REG_WR_IN && (REG_ADDR_IN == `EQSC_ADDR_AEQ_CTL);
   assign wr_byp = REG_WR_IN && (REG_ADDR_IN == `EQSC_ADDR_EQ_BYPASS);

   eqsc_port_ctl u_pri
   (
      .clk_in      (CORE_CLK_IN),
      .reset_in    (RESET_IN),
      .wr_aeq_in   (wr_aeq && !sec_sel),
      .wr_byp_in   (wr_byp && !sec_sel),
      .wdata_in    (REG_WDATA_IN),
      .aeq_ctl_out (pri_aeq),
      .bypass_out  (pri_byp)
   );

   eqsc_port_ctl u_sec
   (
      .clk_in      (CORE_CLK_IN),
      .reset_in    (RESET_IN),
      .wr_aeq_in   (wr_aeq && sec_sel),
      .wr_byp_in   (wr_byp && sec_sel),
      .wdata_in    (REG_WDATA_IN),
      .aeq_ctl_out (sec_aeq),
      .bypass_out  (sec_byp)
   );

   // restart bit lives in the shared bank so either port's write reaches both links
   logic restart_r;
   logic restart_nxt;

   always_comb
   begin
      restart_nxt = restart_r;
      if (wr_aeq)
      begin
         restart_nxt = REG_WDATA_IN[`EQSC_BIT_RESTART];
      end
   end

   // ------------------------------------------------------------------------
   // outputs to analog equalizer and clock generator
   // ------------------------------------------------------------------------
   logic [5:0] pri_set;
   logic [5:0] sec_set;
   logic [5:0] pri_man;
   logic [5:0] sec_man;
   logic [7:0] rdata_nxt;
   logic [2:0] mdiv_nxt;
   logic [1:0] msel_nxt;

   assign pri_man = {pri_byp[`EQSC_MSB_STAGE2:`EQSC_LSB_STAGE2],
                     pri_byp[`EQSC_MSB_STAGE1:`EQSC_LSB_STAGE1]};
   assign sec_man = {sec_byp[`EQSC_MSB_STAGE2:`EQSC_LSB_STAGE2],
                     sec_byp[`EQSC_MSB_STAGE1:`EQSC_LSB_STAGE1]};
   assign pri_set = pri_byp[`EQSC_BIT_BYPASS] ? pri_man : PRI_AEQ_RESULT_IN;
   assign sec_set = sec_byp[`EQSC_BIT_BYPASS] ? sec_man : SEC_AEQ_RESULT_IN;

   function automatic logic [2:0] mdiv_map(input logic [2:0] code);
      logic [2:0] r;
      r = `EQSC_LOG2_DIV1;
      unique case (code)
         3'h0:        r = `EQSC_LOG2_DIV32;
         3'h1:        r = `EQSC_LOG2_DIV16;
         3'h2:        r = `EQSC_LOG2_DIV8;
         3'h3:        r = `EQSC_LOG2_DIV4;
         3'h4, 3'h5:  r = `EQSC_LOG2_DIV2;
         3'h6, 3'h7:  r = `EQSC_LOG2_DIV1;
      endcase
      return r;
   endfunction

   always_comb
   begin
      mdiv_nxt = div_r[`EQSC_BIT_MDIV_OVR]
               ? mdiv_map(div_r[`EQSC_MSB_MDIV:`EQSC_LSB_MDIV])
               : PLL_MDIV_LOG2_IN;
      msel_nxt = div_r[`EQSC_BIT_MSEL_OVR]
               ? div_r[`EQSC_MSB_MSEL:`EQSC_LSB_MSEL]
               : PLL_MSEL_LOG2_IN;
      rdata_nxt = 8'h00;
      unique case (REG_ADDR_IN)
         `EQSC_ADDR_PORT_CTL:   rdata_nxt = port_r;
         `EQSC_ADDR_AEQ_CTL:    rdata_nxt = (sec_sel ? sec_aeq : pri_aeq)
                                            | {1'b0, restart_r, 6'h00};
         `EQSC_ADDR_STRAP_STAT: rdata_nxt = {lstrap_r.valid, lstrap_r.code,
                                             ostrap_r.valid, ostrap_r.code};
         `EQSC_ADDR_MCLK_DIV:   rdata_nxt = div_r;
         `EQSC_ADDR_EQ_STAT:    rdata_nxt = {2'h0, sec_sel ? sec_set : pri_set};
         `EQSC_ADDR_EQ_BYPASS:  rdata_nxt = sec_sel ? sec_byp : pri_byp;
         default:               rdata_nxt = 8'h00;
      endcase
      if (!REG_RD_IN)
      begin
         rdata_nxt = REG_RDATA_OUT;
      end
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RESET_IN)
      begin
         restart_r               <= 1'b0;
         REG_RDATA_OUT           <= 8'h00;
         PRI_EQ_SETTING_OUT      <= 6'h00;
         SEC_EQ_SETTING_OUT      <= 6'h00;
         PRI_EQUALIZER_ADAPT_RESTART_OUT     <= 1'b0;
         SEC_EQUALIZER_ADAPT_RESTART_OUT     <= 1'b0;
         PRI_AEQ_FLOOR_START_OUT <= 1'b0;
         SEC_AEQ_FLOOR_START_OUT <= 1'b0;
         MCLK_MDIV_LOG2_OUT      <= `EQSC_LOG2_DIV32;
         MCLK_MSEL_LOG2_OUT      <= 2'h0;
      end
      else
      begin
         restart_r               <= restart_nxt;
         REG_RDATA_OUT           <= rdata_nxt;
         PRI_EQ_SETTING_OUT      <= pri_set;
         SEC_EQ_SETTING_OUT      <= sec_set;
         // level held while the bit stays one keeps adaptation at its start
         PRI_EQUALIZER_ADAPT_RESTART_OUT     <= restart_r;
         SEC_EQUALIZER_ADAPT_RESTART_OUT     <= restart_r;
         PRI_AEQ_FLOOR_START_OUT <= pri_aeq[`EQSC_BIT_FLOOR_OVR]
                                  & pri_aeq[`EQSC_BIT_FLOOR_SET];
         SEC_AEQ_FLOOR_START_OUT <= sec_aeq[`EQSC_BIT_FLOOR_OVR]
                                  & sec_aeq[`EQSC_BIT_FLOOR_SET];
         MCLK_MDIV_LOG2_OUT      <= mdiv_nxt;
         MCLK_MSEL_LOG2_OUT      <= msel_nxt;
      end
   end

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   sec_write_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      wr_aeq && sec_sel && !wr_port |=> sec_aeq[5:4] == $past(REG_WDATA_IN[5:4])
         && $stable(pri_aeq))
      else $error("secondary aeq write misrouted");
   restart_both_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      wr_aeq |-> ##2 PRI_EQUALIZER_ADAPT_RESTART_OUT == $past(REG_WDATA_IN[6], 2)
         && SEC_EQUALIZER_ADAPT_RESTART_OUT == PRI_EQUALIZER_ADAPT_RESTART_OUT)
      else $error("restart not applied to both links");
   floor_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !pri_aeq[5] |=> !PRI_AEQ_FLOOR_START_OUT)
      else $error("floor start without override");
   floor_start_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      pri_aeq[5] && pri_aeq[4] |=> PRI_AEQ_FLOOR_START_OUT)
      else $error("floor start not driven");
   link_strap_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      lstrap_r.valid |=> lstrap_r.valid && $stable(lstrap_r.code))
      else $error("link strap decode changed after latch");
   out_strap_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      strap_sync_r[0] && !ostrap_r.valid |=> ostrap_r.valid
         && ostrap_r.code == $past(ocode_sync_r))
      else $error("output strap not latched");
   mdiv_ovr_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      div_r[7] && div_r[6:4] == 3'h0 |=> MCLK_MDIV_LOG2_OUT == 3'h5)
      else $error("divide by 32 not selected");
   msel_auto_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !div_r[2] |=> MCLK_MSEL_LOG2_OUT == $past(PLL_MSEL_LOG2_IN))
      else $error("input divide not from pll state machine");
   eq_bypass_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      pri_byp[0] |=> PRI_EQ_SETTING_OUT == $past({pri_byp[3:1], pri_byp[7:5]}))
      else $error("bypass setting not shown");
   eq_read_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      REG_RD_IN && REG_ADDR_IN == 8'h3B && sec_sel |=> REG_RDATA_OUT[5:0] == $past(sec_set))
      else $error("secondary equalizer_setting_status not returned");
endmodule
`default_nettype wire

// ==== rtl/eqsc_defs.svh ====
// register offsets, field positions, reset values and codes of the equalizer/strap/clock bank
`ifndef EQSC_DEFS_SVH
`define EQSC_DEFS_SVH
`define EQSC_ADDR_PORT_CTL      8'h34
`define EQSC_ADDR_AEQ_CTL       8'h35
`define EQSC_ADDR_STRAP_STAT    8'h37
`define EQSC_ADDR_MCLK_DIV      8'h3A
`define EQSC_ADDR_EQ_STAT       8'h3B
`define EQSC_ADDR_EQ_BYPASS     8'h44
`define EQSC_RST_PORT_CTL       8'h01
`define EQSC_RST_AEQ_CTL        8'h00
`define EQSC_RST_MCLK_DIV       8'h00
`define EQSC_RST_EQ_BYPASS      8'h60
`define EQSC_BIT_SEC_SEL        1
`define EQSC_BIT_PRI_SEL        0
`define EQSC_BIT_RESTART        6
`define EQSC_BIT_FLOOR_OVR      5
`define EQSC_BIT_FLOOR_SET      4
`define EQSC_BIT_MDIV_OVR       7
`define EQSC_MSB_MDIV           6
`define EQSC_LSB_MDIV           4
`define EQSC_BIT_MSEL_OVR       2
`define EQSC_MSB_MSEL           1
`define EQSC_LSB_MSEL           0
`define EQSC_MSB_STAGE1         7
`define EQSC_LSB_STAGE1         5
`define EQSC_MSB_STAGE2         3
`define EQSC_LSB_STAGE2         1
`define EQSC_BIT_BYPASS         0
`define EQSC_LOG2_DIV32         3'h5
`define EQSC_LOG2_DIV16         3'h4
`define EQSC_LOG2_DIV8          3'h3
`define EQSC_LOG2_DIV4          3'h2
`define EQSC_LOG2_DIV2          3'h1
`define EQSC_LOG2_DIV1          3'h0
`endif

// ==== rtl/eqsc_pkg.sv ====
// types shared by the equalizer/strap/clock register bank
package eqsc_pkg;
   typedef struct packed
   {
      logic       restart;
      logic       floor_start;
      logic [5:0] manual_setting;
      logic       bypass;
   } eqsc_eq_ctl_type;

   typedef struct packed
   {
      logic       valid;
      logic [2:0] code;
   } eqsc_strap_type;

   typedef struct packed
   {
      logic       mdiv_override;
      logic [2:0] mdiv_log2;
      logic       msel_override;
      logic [1:0] msel_log2;
   } eqsc_clk_ctl_type;
endpackage

// ==== rtl/eqsc_port_ctl.sv ====
// per-link equalizer control bank: bypass register and floor controls of one link
`timescale 1ns/10ps
`default_nettype none
`include "eqsc_defs.svh"
module eqsc_port_ctl
   import eqsc_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       wr_aeq_in,
   input  wire logic       wr_byp_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] aeq_ctl_out,
   output logic      [7:0] bypass_out
);
   logic [7:0] aeq_r;
   logic [7:0] aeq_nxt;
   logic [7:0] byp_r;
   logic [7:0] byp_nxt;

   always_comb
   begin
      aeq_nxt = aeq_r;
      byp_nxt = byp_r;
      if (wr_aeq_in)
      begin
         aeq_nxt = wdata_in & 8'h30;
      end
      if (wr_byp_in)
      begin
         byp_nxt = wdata_in & 8'hEF;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         aeq_r <= `EQSC_RST_AEQ_CTL;
         byp_r <= `EQSC_RST_EQ_BYPASS;
      end
      else
      begin
         aeq_r <= aeq_nxt;
         byp_r <= byp_nxt;
      end
   end

   assign aeq_ctl_out = aeq_r;
   assign bypass_out  = byp_r;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the equalizer/strap/clock register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import eqsc_pkg::*;
;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic       clk      = 1'b0;
   logic       rst      = 1'b1;
   logic       wr       = 1'b0;
   logic       rd       = 1'b0;
   logic [7:0] addr     = 8'h00;
   logic [7:0] wdata    = 8'h00;
   logic       lk_vld   = 1'b0;
   logic [2:0] lk_code  = 3'h0;
   logic       os_vld   = 1'b0;
   logic [2:0] os_code  = 3'h0;
   logic [5:0] pri_res  = 6'h00;
   logic [5:0] sec_res  = 6'h00;
   logic [2:0] pll_mdiv = 3'h0;
   logic [1:0] pll_msel = 2'h0;
   logic [7:0] rdata;
   logic [5:0] pri_eq;
   logic [5:0] sec_eq;
   logic       pri_rst;
   logic       sec_rst;
   logic       pri_flr;
   logic       sec_flr;
   logic [2:0] mdiv;
   logic [1:0] msel;
   int         err_total   = 0;
   int         comparisons = 0;

   always #20 clk = ~clk;

   // ---------------------------------------------------------------
   // design under test
   // ---------------------------------------------------------------
   eqsc_regs dut
   (
      .CORE_CLK_IN             (clk),
      .RESET_IN                (rst),
      .REG_WR_IN               (wr),
      .REG_RD_IN               (rd),
      .REG_ADDR_IN             (addr),
      .REG_WDATA_IN            (wdata),
      .LINK_STRAP_VALID_IN     (lk_vld),
      .LINK_STRAP_CODE_IN      (lk_code),
      .OUT_STRAP_VALID_IN      (os_vld),
      .OUT_STRAP_CODE_IN       (os_code),
      .PRI_AEQ_RESULT_IN       (pri_res),
      .SEC_AEQ_RESULT_IN       (sec_res),
      .PLL_MDIV_LOG2_IN        (pll_mdiv),
      .PLL_MSEL_LOG2_IN        (pll_msel),
      .REG_RDATA_OUT           (rdata),
      .PRI_EQ_SETTING_OUT      (pri_eq),
      .SEC_EQ_SETTING_OUT      (sec_eq),
      .PRI_EQUALIZER_ADAPT_RESTART_OUT     (pri_rst),
      .SEC_EQUALIZER_ADAPT_RESTART_OUT     (sec_rst),
      .PRI_AEQ_FLOOR_START_OUT (pri_flr),
      .SEC_AEQ_FLOOR_START_OUT (sec_flr),
      .MCLK_MDIV_LOG2_OUT      (mdiv),
      .MCLK_MSEL_LOG2_OUT      (msel)
   );

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // synchronous reset clears the sync flops on one edge; hold the full 20 anyway
   task automatic reset_dut;
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
   endtask

   // strobe dropped on the sampling edge: always a single-cycle pulse
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      chk(what, exp, rdata);
   endtask

   // outputs trail their source register by one cycle; allow margin
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   function automatic logic [2:0] mdiv_exp(input logic [2:0] c);
      return (c >= 3'h6) ? 3'h0 : (c >= 3'h4) ? 3'h1 : 3'h5 - c;
   endfunction

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values;
      rd_chk("port_sel", 8'h34, 8'h01);
      rd_chk("aeq_ctl", 8'h35, 8'h00);
      rd_chk("strap_stat", 8'h37, 8'h00);
      rd_chk("mclk_div", 8'h3A, 8'h00);
      rd_chk("eq_stat", 8'h3B, 8'h00);
      rd_chk("bypass", 8'h44, 8'h60);
   endtask

   task automatic t_port_steer;
      wr_reg(8'h35, 8'h10);
      settle;
      chk("pri_floor_gated", 8'h00, {7'h00, pri_flr});
      wr_reg(8'h35, 8'h30);
      settle;
      chk("pri_floor", 8'h01, {7'h00, pri_flr});
      chk("sec_floor_idle", 8'h00, {7'h00, sec_flr});
      wr_reg(8'h34, 8'h02);
      wr_reg(8'h35, 8'h30);
      settle;
      chk("sec_floor", 8'h01, {7'h00, sec_flr});
      rd_chk("sec_aeq_rd", 8'h35, 8'h30);
      wr_reg(8'h34, 8'h01);
      wr_reg(8'h35, 8'h00);
      settle;
      chk("pri_floor_off", 8'h00, {7'h00, pri_flr});
      chk("sec_floor_kept", 8'h01, {7'h00, sec_flr});
   endtask

   task automatic t_restart;
      wr_reg(8'h34, 8'h02);
      wr_reg(8'h35, 8'h40);
      settle;
      chk("restart_both", 8'h03, {6'h00, pri_rst, sec_rst});
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("restart_held", 8'h03, {6'h00, pri_rst, sec_rst});
      rd_chk("restart_rd", 8'h35, 8'h40);
      wr_reg(8'h35, 8'h00);
      settle;
      chk("restart_off", 8'h00, {6'h00, pri_rst, sec_rst});
      wr_reg(8'h34, 8'h01);
   endtask

   task automatic t_equalizer_setting_status;
      pri_res <= 6'h2A;
      sec_res <= 6'h15;
      settle;
      rd_chk("pri_eq_rd", 8'h3B, 8'h2A);
      wr_reg(8'h34, 8'h02);
      rd_chk("sec_eq_rd", 8'h3B, 8'h15);
      wr_reg(8'h44, 8'hB7);
      settle;
      chk("sec_eq_byp", 8'h1D, {2'b00, sec_eq});
      chk("pri_eq_adapt", 8'h2A, {2'b00, pri_eq});
      rd_chk("sec_eq_byp_rd", 8'h3B, 8'h1D);
      rd_chk("byp_rd", 8'h44, 8'hA7);
      wr_reg(8'h34, 8'h01);
      rd_chk("pri_byp_rd", 8'h44, 8'h60);
      wr_reg(8'h44, 8'h2D);
      settle;
      chk("pri_eq_byp", 8'h31, {2'b00, pri_eq});
      chk("sec_eq_kept", 8'h1D, {2'b00, sec_eq});
      rd_chk("pri_eq_byp_rd", 8'h3B, 8'h31);
   endtask

   task automatic t_clock;
      logic [2:0] m;
      @(posedge clk);
      pll_mdiv <= 3'h2;
      pll_msel <= 2'h1;
      settle;
      chk("mdiv_auto", 8'h02, {5'h00, mdiv});
      chk("msel_auto", 8'h01, {6'h00, msel});
      for (int i = 0; i < 8; i++)
      begin
         m = i[2:0];
         wr_reg(8'h3A, {1'b1, m, 2'b01, m[1:0]});
         settle;
         chk("mdiv_ovr", {5'h00, mdiv_exp(m)}, {5'h00, mdiv});
         chk("msel_ovr", {6'h00, m[1:0]}, {6'h00, msel});
      end
      rd_chk("div_rd", 8'h3A, 8'hF7);
      wr_reg(8'h3A, 8'h73);
      settle;
      chk("mdiv_no_ovr", 8'h02, {5'h00, mdiv});
      chk("msel_no_ovr", 8'h01, {6'h00, msel});
      wr_reg(8'h3A, 8'h06);
      settle;
      chk("mdiv_auto_only", 8'h02, {5'h00, mdiv});
      chk("msel_ovr_only", 8'h02, {6'h00, msel});
   endtask

   task automatic t_unmapped;
      wr_reg(8'h36, 8'hFF);
      rd_chk("unmapped_rd", 8'h36, 8'h00);
      rd_chk("sel_kept", 8'h34, 8'h01);
   endtask

   // every strap code once; reset before each since decodes freeze
   task automatic t_straps;
      logic [2:0] c;
      for (int i = 0; i < 8; i++)
      begin
         c = i[2:0];
         reset_dut;
         lk_code <= c;
         os_code <= ~c;
         rd_chk("strap_idle", 8'h37, 8'h00);
         @(posedge clk);
         lk_vld <= 1'b1;
         os_vld <= 1'b1;
         repeat (5) @(posedge clk);
         rd_chk("strap_done", 8'h37, {1'b1, c, 1'b1, ~c});
         @(posedge clk);
         lk_code <= ~c;
         os_code <= c;
         repeat (5) @(posedge clk);
         rd_chk("strap_frozen", 8'h37, {1'b1, c, 1'b1, ~c});
         @(posedge clk);
         lk_vld <= 1'b0;
         os_vld <= 1'b0;
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      reset_dut;
      t_reset_values;
      t_port_steer;
      t_restart;
      t_equalizer_setting_status;
      t_clock;
      t_unmapped;
      t_straps;
      report_and_stop;
   end

   // bounded run: a hung scenario still reaches the verdict
   initial
   begin
      #200000;
      err_total++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      report_and_stop;
   end
endmodule
`default_nettype wire
